// ### src/aicd_params.svh
// constants for the amplifier control-word decoder
// assumes a 16-bit held control word
`ifndef AICD_PARAMS_SVH
`define AICD_PARAMS_SVH
`define AICD_WORD_W 16
`define AICD_GAIN_LO 0
`define AICD_GAIN_HI 2
`define AICD_COMP_HI 5
`define AICD_SEL_LO 6
`define AICD_SEL_HI 7
`define AICD_POL_BIT 8
`define AICD_POWER_DOWN_BIT_BIT 9
`define AICD_EXT_FILTER_ENABLE_BIT 10
`define AICD_PIN_BIT 11
`define AICD_CUR_LO 12
`define AICD_CUR_HI 14
`define AICD_WORD_RST 16'h0000
`define AICD_ADR_WORD 4'h0
`define AICD_ADR_STAT 4'h4
`define AICD_GAIN_EXT 3'h7
`define AICD_CUR_OFF 3'h0
`define AICD_CUR_IDLE 3'h6
`define AICD_CUR_BAD 3'h7
`define AICD_ATT_SHIFT 7'h32
`endif

// ### src/aicd_pkg.sv
// types for the amplifier control-word decoder
// assumes nothing of its surroundings
package aicd_pkg;
   typedef enum logic [1:0] {
      aicd_sel_diff,
      aicd_sel_short,
      aicd_sel_cmp_pos,
      aicd_sel_cmp_neg
   } aicd_sel_type;
endpackage

// ### src/aicd_decode.sv
// combinational decode of the held control word into switch controls
// assumes the word is held stable by the caller
`timescale 1ns/100ps
`default_nettype none
`include "aicd_params.svh"
module aicd_decode
   import aicd_pkg::*;
(
   input wire logic [`AICD_WORD_W-1:0] word_i,
   output logic amp_p_from_pos_o,
   output logic amp_p_from_neg_o,
   output logic amp_n_from_pos_o,
   output logic amp_n_from_neg_o,
   output logic amp_n_to_rail_o,
   output logic atten_en_o,
   output logic gain_negative_o,
   output logic power_down_o,
   output logic feedback_switch_o,
   output logic gain_switch_o,
   output logic unity_stable_o,
   output logic src_to_neg_o,
   output logic [2:0] fault_current_level_o,
   output logic src_connect_o,
   output logic src_powered_o
);
   logic [2:0] gain;
   logic [2:0] cur;
   logic input_polarity;
   logic ext_filter_enable;
   aicd_sel_type input_select;
   assign gain = word_i[`AICD_GAIN_HI:`AICD_GAIN_LO];
   assign cur = word_i[`AICD_CUR_HI:`AICD_CUR_LO];
   assign input_polarity = word_i[`AICD_POL_BIT];
   assign ext_filter_enable = word_i[`AICD_EXT_FILTER_ENABLE_BIT];
   assign input_select = aicd_sel_type'(word_i[`AICD_SEL_HI:`AICD_SEL_LO]);
   always_comb begin
      amp_p_from_pos_o = 1'b0;
      amp_p_from_neg_o = 1'b0;
      amp_n_from_pos_o = 1'b0;
      amp_n_from_neg_o = 1'b0;
      amp_n_to_rail_o = 1'b0;
      atten_en_o = 1'b0;
      gain_negative_o = 1'b0;
      case (input_select)
         aicd_sel_diff: begin
            amp_p_from_pos_o = !input_polarity;
            amp_n_from_neg_o = !input_polarity;
            amp_p_from_neg_o = input_polarity;
            amp_n_from_pos_o = input_polarity;
         end
         aicd_sel_short: begin
            amp_p_from_pos_o = !input_polarity;
            amp_n_from_pos_o = !input_polarity;
            amp_p_from_neg_o = input_polarity;
            amp_n_from_neg_o = input_polarity;
         end
         aicd_sel_cmp_pos: begin
            atten_en_o = 1'b1;
            amp_n_to_rail_o = 1'b1;
            amp_p_from_pos_o = 1'b1;
            gain_negative_o = input_polarity;
         end
         default: begin
            atten_en_o = 1'b1;
            amp_n_to_rail_o = 1'b1;
            amp_p_from_neg_o = 1'b1;
            gain_negative_o = input_polarity;
         end
      endcase
   end
   assign power_down_o = word_i[`AICD_POWER_DOWN_BIT_BIT];
   assign feedback_switch_o = (gain == `AICD_GAIN_EXT) | ext_filter_enable;
   assign gain_switch_o = (gain != `AICD_GAIN_EXT);
   assign unity_stable_o = ext_filter_enable & word_i[`AICD_COMP_HI];
   assign src_to_neg_o = word_i[`AICD_PIN_BIT];
   assign src_connect_o = (cur != `AICD_CUR_OFF) && (cur != `AICD_CUR_IDLE) && (cur != `AICD_CUR_BAD);
   assign src_powered_o = (cur != `AICD_CUR_OFF) && (cur != `AICD_CUR_BAD);
   assign fault_current_level_o = src_connect_o ? cur : `AICD_CUR_OFF;
endmodule // aicd_decode
`default_nettype wire

// ### src/aicd_top.sv
// amplifier control-word register and analog switch control outputs
// assumes a classic Wishbone master on clk_i; word at 0x0, status at 0x4
//
// Contract
// - select 01 pol 0: both to positive
// - select 01 pol 1: both to negative
// - compare mode: divide fifty, rail tie
// - 10 measures positive, 11 negative
// - compare gains 0.2 to 20, polarity negates
// - bit 9 set means shutdown
// - filter bit drives feedback switch
// - gain 111 forces feedback switch closed
// - filter plus comp 1xx: unity stable
// - bit 11 steers current source pin
// - current codes 001..101: 10nA to 100uA
// - 000 off, 110 idle, 111 forbidden
// - gain 2:0, comp 5:3, select 7:6, polarity 8
// - select 00: normal or swapped inputs
`timescale 1ns/100ps
`default_nettype none
`include "aicd_params.svh"
module aicd_top
   import aicd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   output logic amp_p_from_pos_o,
   output logic amp_p_from_neg_o,
   output logic amp_n_from_pos_o,
   output logic amp_n_from_neg_o,
   output logic amp_n_to_rail_o,
   output logic atten_en_o,
   output logic gain_negative_o,
   output logic power_down_o,
   output logic feedback_switch_o,
   output logic gain_switch_o,
   output logic unity_stable_o,
   output logic src_to_neg_o,
   output logic [2:0] fault_current_level_o,
   output logic src_connect_o,
   output logic src_powered_o
);
   logic [`AICD_WORD_W-1:0] word_reg;
   logic bad_code_reg;
   logic [13:0] dec;
   logic [2:0] dec_cur;
   logic req;
   logic hit_word;
   logic hit_stat;
   logic [`AICD_WORD_W-1:0] wr_val;
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   always_comb begin
      hit_word = 1'b0;
      hit_stat = 1'b0;
      if (wb_adr_i == `AICD_ADR_WORD) begin
         hit_word = 1'b1;
      end else if (wb_adr_i == `AICD_ADR_STAT) begin
         hit_stat = 1'b1;
      end
   end
   assign wr_val = {wb_sel_i[1] ? wb_dat_i[15:8] : word_reg[15:8],
                    wb_sel_i[0] ? wb_dat_i[7:0] : word_reg[7:0]};
   // one-cycle ack, err on unmapped address
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req & (hit_word | hit_stat);
         wb_err_o <= req & ~(hit_word | hit_stat);
         if (req & hit_word) begin
            wb_dat_o <= {16'h0000, word_reg};
         end else if (req & hit_stat) begin
            wb_dat_o <= {28'h0000000, bad_code_reg, src_powered_o, src_connect_o, power_down_o};
         end else begin
            wb_dat_o <= 32'h0000_0000;
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         word_reg <= `AICD_WORD_RST;
      end else if (req & hit_word & wb_we_i) begin
         word_reg <= wr_val;
      end
   end
   // forbidden current code flagged, sticky until status write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bad_code_reg <= 1'b0;
      end else if (req & hit_word & wb_we_i & (wr_val[`AICD_CUR_HI:`AICD_CUR_LO] == `AICD_CUR_BAD)) begin
         bad_code_reg <= 1'b1;
      end else if (req & hit_stat & wb_we_i) begin
         bad_code_reg <= 1'b0;
      end
   end
   aicd_decode u_decode (
      .word_i(word_reg),
      .amp_p_from_pos_o(dec[0]),
      .amp_p_from_neg_o(dec[1]),
      .amp_n_from_pos_o(dec[2]),
      .amp_n_from_neg_o(dec[3]),
      .amp_n_to_rail_o(dec[4]),
      .atten_en_o(dec[5]),
      .gain_negative_o(dec[6]),
      .power_down_o(dec[7]),
      .feedback_switch_o(dec[8]),
      .gain_switch_o(dec[9]),
      .unity_stable_o(dec[10]),
      .src_to_neg_o(dec[11]),
      .fault_current_level_o(dec_cur),
      .src_connect_o(dec[12]),
      .src_powered_o(dec[13])
   );
   // registered switch outputs, one cycle after word
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         amp_p_from_pos_o <= 1'b1;
         amp_p_from_neg_o <= 1'b0;
         amp_n_from_pos_o <= 1'b0;
         amp_n_from_neg_o <= 1'b1;
         amp_n_to_rail_o <= 1'b0;
         atten_en_o <= 1'b0;
         gain_negative_o <= 1'b0;
         power_down_o <= 1'b0;
         feedback_switch_o <= 1'b0;
         gain_switch_o <= 1'b1;
         unity_stable_o <= 1'b0;
         src_to_neg_o <= 1'b0;
         fault_current_level_o <= `AICD_CUR_OFF;
         src_connect_o <= 1'b0;
         src_powered_o <= 1'b0;
      end else begin
         amp_p_from_pos_o <= dec[0];
         amp_p_from_neg_o <= dec[1];
         amp_n_from_pos_o <= dec[2];
         amp_n_from_neg_o <= dec[3];
         amp_n_to_rail_o <= dec[4];
         atten_en_o <= dec[5];
         gain_negative_o <= dec[6];
         power_down_o <= dec[7];
         feedback_switch_o <= dec[8];
         gain_switch_o <= dec[9];
         unity_stable_o <= dec[10];
         src_to_neg_o <= dec[11];
         fault_current_level_o <= dec_cur;
         src_connect_o <= dec[12];
         src_powered_o <= dec[13];
      end
   end
endmodule // aicd_top
`default_nettype wire

// ### sim/aicd_sva.sv
// assertions on the control-word decoder ports
// bound into aicd_top; a word write shows at the outputs one cycle after ack
`timescale 1ns/100ps
`default_nettype none
module aicd_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic amp_p_from_pos_o,
   input wire logic amp_n_from_neg_o,
   input wire logic atten_en_o,
   input wire logic power_down_o,
   input wire logic feedback_switch_o,
   input wire logic src_to_neg_o,
   input wire logic [2:0] fault_current_level_o,
   input wire logic src_connect_o,
   input wire logic src_powered_o
);
   logic wa;
   logic wr;
   logic req;
   assign wa = wb_ack_o & wb_we_i & (wb_adr_i == 4'h0);
   assign wr = wa & (wb_sel_i[1:0] == 2'b11);
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   a_answer_next: assert property (req |=> wb_ack_o || wb_err_o) else $error("no answer after one cycle");
   a_err_unmapped: assert property (req && wb_adr_i != 4'h0 && wb_adr_i != 4'h4 |=> wb_err_o && !wb_ack_o)
      else $error("unmapped address not refused");
   a_power_down_bit_bit: assert property (wr |=> power_down_o == $past(wb_dat_i[9])) else $error("shutdown wrong");
   a_fb_switch: assert property (wr |=> feedback_switch_o ==
      ($past(wb_dat_i[10]) || $past(wb_dat_i[2:0]) == 3'h7)) else $error("feedback switch wrong");
   a_pin_steer: assert property (wr |=> src_to_neg_o == $past(wb_dat_i[11])) else $error("pin steer wrong");
   a_cur_level: assert property (wr && wb_dat_i[14:12] inside {[1:5]} |=> src_connect_o && src_powered_o
      && fault_current_level_o == $past(wb_dat_i[14:12])) else $error("current level wrong");
   a_cur_idle: assert property (wr && wb_dat_i[14:12] inside {0, 6, 7} |=> !src_connect_o
      && fault_current_level_o == 3'h0 && src_powered_o == ($past(wb_dat_i[14:12]) == 3'h6))
      else $error("source off codes wrong");
   a_diff_route: assert property (wr && wb_dat_i[8:6] == 3'h0 |=> amp_p_from_pos_o && amp_n_from_neg_o
      && !atten_en_o) else $error("differential routing wrong");
   a_hold_outputs: assert property (!wa |=> $stable(power_down_o) && $stable(fault_current_level_o)
      && $stable(feedback_switch_o)) else $error("outputs moved without a write");
   c_fault_word: cover property (wr && wb_dat_i[15:0] == 16'h5082);
   c_compare: cover property (wr && wb_dat_i[7]);
   c_unmapped: cover property (wb_err_o);
endmodule // aicd_sva
bind aicd_top aicd_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .wb_err_o(wb_err_o), .amp_p_from_pos_o(amp_p_from_pos_o), .amp_n_from_neg_o(amp_n_from_neg_o),
   .atten_en_o(atten_en_o), .power_down_o(power_down_o), .feedback_switch_o(feedback_switch_o),
   .src_to_neg_o(src_to_neg_o), .fault_current_level_o(fault_current_level_o),
   .src_connect_o(src_connect_o), .src_powered_o(src_powered_o));
`default_nettype wire

// ### sim/aicd_host_model.sv
// classic wishbone master standing for the host controller
// caller enters the task just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module aicd_host_model (
   input wire logic clk_i,
   input wire logic [31:0] dat_i,
   input wire logic ack_i,
   input wire logic err_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [3:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o
);
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 4'h0;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end
   // filter and code 111 only when a test asks
   task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      sel_o <= s;
      dat_o <= d;
      @(posedge clk_i);
      while (!(ack_i | err_i)) @(posedge clk_i);
      q = dat_i;
      e = err_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      dat_o <= ~d;
   endtask
endmodule // aicd_host_model
`default_nettype wire

// ### sim/aicd_top_bench.sv
// self-checking bench for the control-word decoder
// host model drives the bus; a decode model predicts every output
`timescale 1ns/100ps
`default_nettype none
`define AICD_CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
   $display("mismatch at %0t got %h exp %h", $time, a, b); end end
module aicd_top_bench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   wire logic cyc, stb, we, ack, err;
   wire logic [3:0] adr, sel;
   wire logic [31:0] dwr, drd;
   wire logic [16:0] outs;
   logic [15:0] m, w;
   logic [16:0] x;
   logic [31:0] q;
   logic e;
   int bad_count = 0, tests_run = 0, cyc_n = 0;
   logic [15:0] fw [5] = '{16'h0082, 16'h00c2, 16'h5082, 16'h58c2, 16'h5000};
   always #2 clk_i = ~clk_i;
   aicd_host_model u_host (.clk_i(clk_i), .dat_i(drd), .ack_i(ack), .err_i(err), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dwr));
   aicd_top u_aicd_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dwr), .wb_dat_o(drd), .wb_ack_o(ack), .wb_err_o(err),
      .amp_p_from_pos_o(outs[16]), .amp_p_from_neg_o(outs[15]), .amp_n_from_pos_o(outs[14]),
      .amp_n_from_neg_o(outs[13]), .amp_n_to_rail_o(outs[12]), .atten_en_o(outs[11]),
      .gain_negative_o(outs[10]), .power_down_o(outs[9]), .feedback_switch_o(outs[8]),
      .gain_switch_o(outs[7]), .unity_stable_o(outs[6]), .src_to_neg_o(outs[5]),
      .fault_current_level_o(outs[4:2]), .src_connect_o(outs[1]), .src_powered_o(outs[0]));
   function automatic logic [16:0] dec(input logic [15:0] v);
      logic [4:0] rt [8];
      logic [2:0] c;
      logic cn;
      rt = '{5'h12, 5'h0c, 5'h14, 5'h0a, 5'h11, 5'h11, 5'h09, 5'h09};
      c = v[14:12];
      cn = (c != 3'h0) && (c < 3'h6);
      return {rt[{v[7:6], v[8]}], v[7], v[7] & v[8], v[9], v[10] | (v[2:0] == 3'h7), v[2:0] != 3'h7,
         v[10] & v[5], v[11], cn ? c : 3'h0, cn, (c != 3'h0) && (c != 3'h7)};
   endfunction
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic go(input logic wn, input logic [3:0] a, input logic [3:0] s, input logic [15:0] d);
      @(posedge clk_i);
      u_host.bus(wn, a, s, {16'h0, d}, q, e);
      @(negedge clk_i);
   endtask
   task automatic put(input logic [3:0] s, input logic [15:0] d);
      go(1'b1, 4'h0, s, d);
      if (s[0]) m[7:0] = d[7:0];
      if (s[1]) m[15:8] = d[15:8];
      `AICD_CHK(outs, dec(m))
      go(1'b0, 4'h0, 4'hf, 16'h0);
      `AICD_CHK(q, {16'h0, m})
   endtask
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 4000) begin
         bad_count++;
         wrap_up;
      end
   end
   initial begin
      void'($urandom(234));
      m = 16'h0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      `AICD_CHK(outs, dec(m))
      for (int i = 0; i < 8; i++) put(4'h3, {1'b0, i[2:0], i[0], i[1], i[2], i[2:0], i[2:0], 3'(7 - i)});
      foreach (fw[k]) put(4'h3, fw[k]);
      put(4'h1, 16'h3cff);
      put(4'h2, 16'h0100);
      $display("code table and lanes done");
      put(4'h3, 16'h7000);
      go(1'b0, 4'h4, 4'hf, 16'h0);
      x = dec(m);
      `AICD_CHK(q, {28'h0, 1'b1, x[0], x[1], x[9]})
      go(1'b1, 4'h4, 4'h1, 16'h0);
      go(1'b0, 4'h4, 4'hf, 16'h0);
      `AICD_CHK(q[3], 1'b0)
      go(1'b1, 4'h8, 4'h3, 16'h1234);
      `AICD_CHK(e, 1'b1)
      go(1'b0, 4'h0, 4'hf, 16'h0);
      `AICD_CHK(q, {16'h0, m})
      $display("status and refusal done");
      repeat (24) begin
         w = 16'($urandom);
         if (w[14:12] == 3'h7) w[14] = 1'b0;
         put(4'h3, w);
      end
      $display("random words done");
      wrap_up;
   end
endmodule // aicd_top_bench
`default_nettype wire
